// ===== verilog/fpcsr_pkg.sv
// package: register layout, field positions and reset values of the fp control registers
package fpcsr_pkg;

	// ----------------------------------------
	// control register numbers
	// ----------------------------------------
	localparam logic [4:0] FPCSR_IMPL_REV_NUM = 5'h00; // implementation/revision register
	localparam logic [4:0] FPCSR_CTRL_STAT_NUM = 5'h1f; // control/status register

	// ----------------------------------------
	// control/status field positions
	// ----------------------------------------
	localparam int FPCSR_RND_LSB = 0; // rounding field [1:0]
	localparam int FPCSR_FLAG_LSB = 2; // flags [6:2]
	localparam int FPCSR_EN_LSB = 7; // enables [11:7]
	localparam int FPCSR_CAUSE_LSB = 12; // cause [17:12]
	localparam int FPCSR_COND_BIT = 23; // compare condition
	localparam int FPCSR_FLUSH_BIT = 24; // flush denormal enable

	// ----------------------------------------
	// exception bit positions inside a 5-bit field
	// ----------------------------------------
	localparam int FPCSR_X_INEXACT = 0;
	localparam int FPCSR_X_UNDER = 1;
	localparam int FPCSR_X_OVER = 2;
	localparam int FPCSR_X_DIVZ = 3;
	localparam int FPCSR_X_INVALID = 4;
	localparam int FPCSR_X_UNIMPL = 5; // cause field only

	// ----------------------------------------
	// reset values and identity
	// ----------------------------------------
	localparam logic [31:0] FPCSR_CTRL_RESET = 32'h0000_0000;
	localparam logic [7:0] FPCSR_IMPL_DEFAULT = 8'h5a; // arbitrary value
	localparam logic [3:0] FPCSR_MAJOR_DEFAULT = 4'h1;
	localparam logic [3:0] FPCSR_MINOR_DEFAULT = 4'h0;

	// rounding modes
	typedef enum logic [1:0] {
		round_nearest_even = 2'h0,
		round_toward_zero = 2'h1,
		round_toward_plus_inf = 2'h2,
		round_toward_minus_inf = 2'h3
	} fpcsr_rnd_t;

	// class of the retiring fp instruction
	typedef enum logic [2:0] {
		FPCSR_OP_NONE = 3'h0, // no fp instruction
		FPCSR_OP_ARITH = 3'h1, // computational or conversion
		FPCSR_OP_COMPARE = 3'h2, // compare
		FPCSR_OP_MOVE = 3'h3, // fp_register_move and loads/stores
		FPCSR_OP_UNIMPL = 3'h4 // reserved or unimplemented
	} fpcsr_op_t;

endpackage

// ===== verilog/fpcsr_exc_if.sv
// interface: exception status passed between the register file and its helpers
`timescale 1ns/1ps
`default_nettype none
interface fpcsr_exc_if;
	logic [5:0] cause; // current cause field
	logic [4:0] enable; // current enable field
	logic trap; // pending exception
	modport src (output cause, output enable, input trap);
	modport chk (input cause, input enable, output trap);
endinterface
`default_nettype wire

// ===== verilog/fpcsr_trap_detect.sv
// module: trap condition from cause and enable fields
`timescale 1ns/1ps
`default_nettype none
module fpcsr_trap_detect
	import fpcsr_pkg::*;
(
	fpcsr_exc_if.chk exc
);
	// enabled cause, plus unimplemented which has no enable
	assign exc.trap = (|(exc.cause[4:0] & exc.enable)) | exc.cause[FPCSR_X_UNIMPL];
endmodule
`default_nettype wire

// ===== verilog/fpcsr_flush.sv
// module: flush decision and flushed value for denormal results
`timescale 1ns/1ps
`default_nettype none
module fpcsr_flush
	import fpcsr_pkg::*;
(
	input wire logic flush_en,
	input wire logic [4:0] enable,
	input wire fpcsr_pkg::fpcsr_rnd_t rnd,
	input wire logic denorm,
	input wire logic sign,
	output logic do_flush,
	output logic to_min_norm
)
;
	// flush only with underflow and inexact traps off
	assign do_flush = denorm & flush_en & ~enable[FPCSR_X_UNDER] & ~enable[FPCSR_X_INEXACT];
	// away from zero only when rounding points that way
	assign to_min_norm = sign ? (rnd == round_toward_minus_inf) : (rnd == round_toward_plus_inf);
endmodule
`default_nettype wire

// ===== verilog/fpcsr_regs.sv
// module: fp control register bank, implementation/revision and control/status
//
// Operation
// - revision register read-only, major in 7:4
// - minor revision number in bits 3:0
// - reserved revision bits read as zero
// - status register accessible without privilege check
// - flush denormals when enabled, traps off
// - flush value depends on sign and rounding
// - flush sets underflow, inexact cause and flag
// - compare writes condition bit 23
// - condition changes only on compare, write
// - branches sample the condition bit
// - only listed instructions update cause, flags
// - cause holds all exceptions of last op
// - unimplemented cause set when emulation needed
// - trapped op changes cause bits only
// - trap whenever cause and enable both set
// - unimplemented cause always traps
// - unenabled exceptions store default result
// - flags accumulate, cleared only by write
// - rounding field selects rounding mode
// - move instructions read and write registers
// - writes visible to very next instruction
`timescale 1ns/1ps
`default_nettype none
module fpcsr_regs
	import fpcsr_pkg::*;
#(
	parameter logic [7:0] IMPL_NUM = fpcsr_pkg::FPCSR_IMPL_DEFAULT, // arbitrary value
	parameter logic [3:0] MAJOR_REV = fpcsr_pkg::FPCSR_MAJOR_DEFAULT,
	parameter logic [3:0] MINOR_REV = fpcsr_pkg::FPCSR_MINOR_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic nrst,
	// control move port
	input wire logic ctl_rd, // move_from_fp_control
	input wire logic [4:0] ctl_rd_num,
	output logic [31:0] ctl_rd_data,
	input wire logic ctl_wr, // move_to_fp_control
	input wire logic [4:0] ctl_wr_num,
	input wire logic [31:0] ctl_wr_data,
	// retiring fp instruction
	input wire logic op_valid,
	input wire fpcsr_pkg::fpcsr_op_t op_class,
	input wire logic [4:0] op_exc, // ieee exceptions raised, order of enable field
	input wire logic op_denorm, // result is denormal
	input wire logic op_sign, // sign of that result
	input wire logic cmp_result, // compare outcome
	// answers to the datapath
	output logic res_write_ok, // datapath may write result
	output logic res_flush, // substitute flushed value
	output logic res_min_norm, // flushed value is +-2^emin
	output logic [1:0] rnd_mode,
	output logic cond_flag,
	output logic fp_exc_req
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic flush_q, flush_d; // flush denormal enable
	logic cond_q, cond_d; // compare condition
	logic [5:0] cause_q, cause_d; // cause field
	logic [4:0] enable_q, enable_d; // enable field
	logic [4:0] flag_q, flag_d; // flag field
	logic [1:0] rnd_q, rnd_d; // rounding field
	logic [31:0] rd_q; // read data register
	logic ok_q, fl_q, mn_q, req_q; // registered answers

	fpcsr_exc_if exc_cur(); // current state view
	fpcsr_exc_if exc_nxt(); // next state view

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire wr_ctrl = ctl_wr & (ctl_wr_num == FPCSR_CTRL_STAT_NUM);
	wire op_arith = op_valid & (op_class == FPCSR_OP_ARITH);
	wire op_cmp = op_valid & (op_class == FPCSR_OP_COMPARE);
	wire op_unimp_cls = op_valid & (op_class == FPCSR_OP_UNIMPL);
	wire op_upd = op_arith | op_unimp_cls;
	wire do_flush;
	wire to_min;
	wire flush_needed = op_arith & op_denorm; // denormal arithmetic result
	wire flush_now = op_arith & do_flush;

	// flush decision uses the value written in the same cycle
	fpcsr_flush u_flush (
		.flush_en(flush_d),
		.enable(enable_d),
		.rnd(fpcsr_rnd_t'(rnd_d)),
		.denorm(op_denorm),
		.sign(op_sign),
		.do_flush(do_flush),
		.to_min_norm(to_min)
	);

	// exceptions raised by this op
	wire [4:0] flush_exc = flush_now ? 5'h03 : 5'h00;
	wire [4:0] op_ieee = op_exc | flush_exc;
	wire unimp_now = op_unimp_cls | (flush_needed & ~do_flush);
	wire [5:0] op_cause = {unimp_now, op_ieee};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		flush_d = flush_q;
		cond_d = cond_q;
		cause_d = cause_q;
		enable_d = enable_q;
		flag_d = flag_q;
		rnd_d = rnd_q;
		// control write first; an op in the same cycle sees it
		if (wr_ctrl) begin
			flush_d = ctl_wr_data[FPCSR_FLUSH_BIT];
			cond_d = ctl_wr_data[FPCSR_COND_BIT];
			cause_d = ctl_wr_data[FPCSR_CAUSE_LSB +: 6];
			enable_d = ctl_wr_data[FPCSR_EN_LSB +: 5];
			flag_d = ctl_wr_data[FPCSR_FLAG_LSB +: 5];
			rnd_d = ctl_wr_data[FPCSR_RND_LSB +: 2];
		end
		// compare sets or clears the condition
		if (op_cmp) begin
			cond_d = cmp_result;
		end
		// updating op replaces cause wholesale
		if (op_upd) begin
			cause_d = op_cause;
		end
		// flags only set by ops when no trap is taken
		if (op_upd & ~exc_nxt.trap) begin
			flag_d = flag_d | op_ieee;
		end
	end

	assign exc_nxt.cause = cause_d;
	assign exc_nxt.enable = enable_d;
	assign exc_cur.cause = cause_q;
	assign exc_cur.enable = enable_q;

	// trap checks on the next and the stored state
	fpcsr_trap_detect u_trap_nxt (
		.exc(exc_nxt)
	);
	fpcsr_trap_detect u_trap_cur (
		.exc(exc_cur)
	);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire [31:0] impl_word = {16'h0000, IMPL_NUM, MAJOR_REV, MINOR_REV};
	wire [31:0] ctrl_word = {7'h00, flush_q, cond_q, 5'h00, cause_q, enable_q, flag_q, rnd_q};
	wire [31:0] rd_mux = (ctl_rd_num == FPCSR_IMPL_REV_NUM) ? impl_word :
		(ctl_rd_num == FPCSR_CTRL_STAT_NUM) ? ctrl_word : 32'h0000_0000;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// architectural fields
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			flush_q <= FPCSR_CTRL_RESET[FPCSR_FLUSH_BIT];
			cond_q <= FPCSR_CTRL_RESET[FPCSR_COND_BIT];
			cause_q <= FPCSR_CTRL_RESET[FPCSR_CAUSE_LSB +: 6];
			enable_q <= FPCSR_CTRL_RESET[FPCSR_EN_LSB +: 5];
			flag_q <= FPCSR_CTRL_RESET[FPCSR_FLAG_LSB +: 5];
			rnd_q <= FPCSR_CTRL_RESET[FPCSR_RND_LSB +: 2];
		end else begin
			flush_q <= flush_d;
			cond_q <= cond_d;
			cause_q <= cause_d;
			enable_q <= enable_d;
			flag_q <= flag_d;
			rnd_q <= rnd_d;
		end
	end

	// read data register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_q <= 32'h0000_0000;
		end else if (ctl_rd) begin
			rd_q <= rd_mux;
		end
	end

	// answers to the datapath
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ok_q <= 1'b0;
			fl_q <= 1'b0;
			mn_q <= 1'b0;
			req_q <= 1'b0;
		end else begin
			ok_q <= op_arith & ~exc_nxt.trap;
			fl_q <= flush_now & ~exc_nxt.trap;
			mn_q <= flush_now & to_min & ~exc_nxt.trap;
			req_q <= exc_nxt.trap;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign ctl_rd_data = rd_q;
	assign res_write_ok = ok_q;
	assign res_flush = fl_q;
	assign res_min_norm = mn_q;
	assign rnd_mode = rnd_q;
	assign cond_flag = cond_q;
	assign fp_exc_req = req_q;

endmodule
`default_nettype wire

// ===== sim/fpcsr_regs_props.sv
// checker: port-level properties of the fp control register bank
`timescale 1ns/1ps
`default_nettype none
module fpcsr_regs_props
	import fpcsr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ctl_wr,
	input wire logic [4:0] ctl_wr_num,
	input wire logic [31:0] ctl_wr_data,
	input wire logic op_valid,
	input wire fpcsr_pkg::fpcsr_op_t op_class,
	input wire logic cmp_result,
	input wire logic res_write_ok,
	input wire logic res_min_norm,
	input wire logic res_flush,
	input wire logic [1:0] rnd_mode,
	input wire logic cond_flag,
	input wire logic fp_exc_req
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// decoded requests and written fields
	wire wr_csr = ctl_wr && (ctl_wr_num == FPCSR_CTRL_STAT_NUM);
	wire is_cmp = op_valid && (op_class == FPCSR_OP_COMPARE);
	wire wr_c = ctl_wr_data[23];
	wire [1:0] wr_rm = ctl_wr_data[1:0];
	wire wr_trap = ctl_wr_data[17] | (|(ctl_wr_data[16:12] & ctl_wr_data[11:7]));
	property p_cmp; is_cmp |=> cond_flag == $past(cmp_result); endproperty
	a_cmp: assert property (p_cmp) else $error("cond not compare outcome");
	property p_hold; !is_cmp && !wr_csr |=> $stable(cond_flag); endproperty
	a_hold: assert property (p_hold) else $error("cond moved");
	property p_wrc; wr_csr && !is_cmp |=> cond_flag == $past(wr_c); endproperty
	a_wrc: assert property (p_wrc) else $error("cond write lost");
	property p_rm; wr_csr |=> rnd_mode == $past(wr_rm); endproperty
	a_rm: assert property (p_rm) else $error("rounding write lost");
	property p_wtrap; wr_csr && !op_valid |=> fp_exc_req == $past(wr_trap); endproperty
	a_wtrap: assert property (p_wtrap) else $error("trap after write wrong");
	property p_unimp; op_valid && op_class == FPCSR_OP_UNIMPL |=> fp_exc_req; endproperty
	a_unimp: assert property (p_unimp) else $error("no trap on unimpl");
	property p_commit; res_write_ok |-> !fp_exc_req; endproperty
	a_commit: assert property (p_commit) else $error("result kept on trap");
	property p_minn; res_min_norm |-> res_flush; endproperty
	a_minn: assert property (p_minn) else $error("min norm without flush");
endmodule
bind fpcsr_regs fpcsr_regs_props u_props (.*);
`default_nettype wire

// ===== sim/fpcsr_core_model.sv
// partner: core side that takes fp trap requests
`timescale 1ns/1ps
`default_nettype none
module fpcsr_core_model (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic fp_exc_req,
	output logic [7:0] trap_cnt_q
);
	logic req_q; // request seen last cycle
	// one handler entry per new request
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			req_q <= 1'h0;
			trap_cnt_q <= 8'h00;
		end else begin
			req_q <= fp_exc_req;
			trap_cnt_q <= trap_cnt_q + {7'h00, fp_exc_req && !req_q};
		end
	end
endmodule
`default_nettype wire

// ===== sim/tb_fpcsr_regs.sv
// testbench: scenarios for the fp control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_fpcsr_regs;
	import fpcsr_pkg::*;
	localparam logic [31:0] REV = {16'h0, FPCSR_IMPL_DEFAULT,
		FPCSR_MAJOR_DEFAULT, FPCSR_MINOR_DEFAULT};
	logic clk_sys = 1'h0, nrst = 1'h0, ctl_rd = 1'h0, ctl_wr = 1'h0, op_valid = 1'h0;
	logic op_denorm = 1'h0, op_sign = 1'h0, cmp_result = 1'h0;
	logic [4:0] ctl_rd_num = 5'h00, ctl_wr_num = 5'h00, op_exc = 5'h00;
	logic [31:0] ctl_wr_data = 32'h0, ctl_rd_data;
	fpcsr_op_t op_class = FPCSR_OP_NONE;
	logic res_write_ok, res_flush, res_min_norm, cond_flag, fp_exc_req;
	logic [1:0] rnd_mode;
	logic [7:0] trap_cnt_q;
	int err_total = 0, n_tests = 0;
	fpcsr_regs uut (.*);
	fpcsr_core_model core (.*);
	initial forever #4 clk_sys = ~clk_sys;
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// control move in, one pulse
	task automatic wr(input logic [4:0] n, input logic [31:0] d);
		@(negedge clk_sys) {ctl_wr, ctl_wr_num, ctl_wr_data} = {1'h1, n, d};
		@(negedge clk_sys) ctl_wr = 1'h0;
	endtask
	// control move out, data one edge later
	task automatic rd(input logic [4:0] n, input logic [31:0] e);
		@(negedge clk_sys) {ctl_rd, ctl_rd_num} = {1'h1, n};
		@(negedge clk_sys) ctl_rd = 1'h0;
		chk(ctl_rd_data, e);
	endtask
	// retire one fp instruction, d is denorm, sign, compare outcome
	task automatic op(input fpcsr_op_t c, input logic [4:0] x, input logic [2:0] d);
		op_class = c;
		@(negedge clk_sys) {op_valid, op_exc, op_denorm, op_sign, cmp_result} = {1'h1, x, d};
		@(negedge clk_sys) op_valid = 1'h0;
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// reset values, read-only revision, full write
	task automatic t_regs;
		rd(5'h1f, FPCSR_CTRL_RESET);
		rd(5'h00, REV);
		wr(5'h00, 32'hffff_ffff);
		rd(5'h00, REV);
		rd(5'h05, 32'h0);
		wr(5'h1f, 32'hffff_ffff);
		chk(fp_exc_req, 1'h1);
		rd(5'h1f, 32'h0183_ffff);
		wr(5'h1f, 32'h0);
		chk(fp_exc_req, 1'h0);
	endtask
	// condition bit set, held, cleared
	task automatic t_cond;
		op(FPCSR_OP_COMPARE, 5'h00, 3'h1);
		chk(cond_flag, 1'h1);
		op(FPCSR_OP_ARITH, 5'h00, 3'h0);
		chk(cond_flag, 1'h1);
		op(FPCSR_OP_COMPARE, 5'h00, 3'h0);
		chk(cond_flag, 1'h0);
	endtask
	// cause, flags, traps
	task automatic t_exc;
		op(FPCSR_OP_ARITH, 5'h05, 3'h0);
		chk(res_write_ok, 1'h1);
		rd(5'h1f, 32'h0000_5014);
		op(FPCSR_OP_ARITH, 5'h08, 3'h0);
		op(FPCSR_OP_MOVE, 5'h1f, 3'h0);
		rd(5'h1f, 32'h0000_8034);
		wr(5'h1f, 32'h0000_0400);
		op(FPCSR_OP_ARITH, 5'h08, 3'h0);
		chk(res_write_ok, 1'h0);
		rd(5'h1f, 32'h0000_8400);
		wr(5'h1f, 32'h0);
		op(FPCSR_OP_UNIMPL, 5'h00, 3'h0);
		rd(5'h1f, 32'h0002_0000);
		wr(5'h1f, 32'h0);
	endtask
	// flush in every rounding mode and sign, then blocked
	task automatic t_flush;
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 2; s++) begin
				wr(5'h1f, 32'h0100_0000 | m);
				chk(rnd_mode, m[1:0]);
				op(FPCSR_OP_ARITH, 5'h00, {1'h1, s[0], 1'h0});
				chk(res_flush, 1'h1);
				chk(res_min_norm, (m == 2 && s == 0) || (m == 3 && s == 1));
				rd(5'h1f, 32'h0100_300c | m);
			end
		end
		wr(5'h1f, 32'h0100_0100);
		op(FPCSR_OP_ARITH, 5'h00, 3'h4);
		chk(res_flush, 1'h0);
		chk(fp_exc_req, 1'h1);
		wr(5'h1f, 32'h0);
	endtask
	initial begin
		repeat (4) @(negedge clk_sys);
		nrst = 1'h1;
		t_regs();
		t_cond();
		t_exc();
		t_flush();
		chk(trap_cnt_q, 8'h04);
		results();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		$display("MISMATCH %0t run timed out", $time);
		results();
	end
endmodule
`default_nettype wire
